// ==== dfgc_defs.svh ====
// Constants for the display FIFO general configuration block
// Contract
// R1: Test bit exposes FIFO and line buffer (the code drives only fifo_test_mode_out, no line buffer output)
// R2: Test bit rising edge resets pointers
// R3: Line repeat sends odd lines as copies
// R4: Software programs undoubled timing, half lines
// R5: Whole-frame dirty on any pixel write
// R6: Otherwise mark only the written line dirty
// R7: Insert one static frame between updates
// R8: Static frames skip dirty refresh, fetch failures
// R9: Urgent fill starts at begin level
// R10: Urgent fill ends at stop level
// R11: Software keeps stop level above begin level
`ifndef DFGC_DEFS_SVH
`define DFGC_DEFS_SVH
`define DFGC_ADDR_W 16
`define DFGC_CFG_OFS 16'h8304
`define DFGC_STAT_OFS 16'h8310
`define DFGC_CFG_RESET 32'h0000_0000
`define DFGC_CFG_WMASK 32'h0305_FF00
`define DFGC_BIT_TEST 25
`define DFGC_BIT_REPEAT 24
`define DFGC_BIT_ALLDIRTY 18
`define DFGC_BIT_INSERT 16
`define DFGC_STOP_HI 15
`define DFGC_STOP_LO 12
`define DFGC_BEGIN_HI 11
`define DFGC_BEGIN_LO 8
`define DFGC_LEVEL_SHIFT 2
`define DFGC_ST_URGENT 0
`define DFGC_ST_UPDATE 1
`define DFGC_ST_TEST 2
`define DFGC_ST_LINEODD 3
`endif

// ==== dfgc_pkg.sv ====
// Types for the display FIFO general configuration block
package dfgc_pkg;
   typedef struct packed {
      logic test_mode;
      logic repeat_en;
      logic all_dirty;
      logic insert;
      logic [3:0] stop_lvl;
      logic [3:0] begin_lvl;
   } dfgc_cfg_s;
   typedef enum logic [1:0] {
      DFGC_UPDATE = 2'b01,
      DFGC_STATIC = 2'b10
   } dfgc_frame_e;
endpackage

// ==== dfgc_top.sv ====
// Display FIFO general configuration register and its control logic
`include "dfgc_defs.svh"
module dfgc_top #(
   parameter int LINE_W = 11,
   parameter int DEPTH_W = 8
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [`DFGC_ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [DEPTH_W-1:0] fifo_depth_in,
   input wire logic frame_start_in,
   input wire logic line_start_in,
   input wire logic pixel_write_in,
   input wire logic [LINE_W-1:0] pixel_line_in,
   output logic fifo_test_mode_out,
   output logic fifo_ptr_reset_out,
   output logic line_repeat_out,
   output logic dirty_set_out,
   output logic dirty_all_out,
   output logic [LINE_W-1:0] dirty_line_out,
   output logic update_frame_out,
   output logic urgent_fill_req_out
);
   if (LINE_W < 1 || LINE_W > 16) begin : g_line_w_bad
      $error("LINE_W out of range");
   end
   if (DEPTH_W < 6 || DEPTH_W > 16) begin : g_depth_w_bad
      $error("DEPTH_W must hold level 60");
   end

   function automatic logic [DEPTH_W-1:0] lvl_entries(input logic [3:0] lvl);
      lvl_entries = DEPTH_W'(lvl) << `DFGC_LEVEL_SHIFT;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // APB slave
   dfgc_pkg::dfgc_cfg_s cfg_q, cfg_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic urgent_q, urgent_d;
   logic line_odd_q, line_odd_d;
   dfgc_pkg::dfgc_frame_e frame_q, frame_d;
   logic [31:0] cfg_word;
   logic [31:0] stat_word;
   logic hit_cfg;
   logic hit_stat;
   logic setup;

   always_comb begin
      cfg_word = 32'h0000_0000;
      cfg_word[`DFGC_BIT_TEST] = cfg_q.test_mode;
      cfg_word[`DFGC_BIT_REPEAT] = cfg_q.repeat_en;
      cfg_word[`DFGC_BIT_ALLDIRTY] = cfg_q.all_dirty;
      cfg_word[`DFGC_BIT_INSERT] = cfg_q.insert;
      cfg_word[`DFGC_STOP_HI:`DFGC_STOP_LO] = cfg_q.stop_lvl;
      cfg_word[`DFGC_BEGIN_HI:`DFGC_BEGIN_LO] = cfg_q.begin_lvl;
      stat_word = 32'h0000_0000;
      stat_word[`DFGC_ST_URGENT] = urgent_q;
      stat_word[`DFGC_ST_UPDATE] = (frame_q == dfgc_pkg::DFGC_UPDATE);
      stat_word[`DFGC_ST_TEST] = cfg_q.test_mode;
      stat_word[`DFGC_ST_LINEODD] = line_odd_q;
   end

   assign setup = psel_in && !penable_in;
   assign hit_cfg = (paddr_in == `DFGC_CFG_OFS);
   assign hit_stat = (paddr_in == `DFGC_STAT_OFS);

   always_comb begin
      cfg_d = cfg_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      if (setup) begin
         pready_d = 1'b1;
         pslverr_d = !(hit_cfg || hit_stat) || (hit_stat && pwrite_in);
         prdata_d = hit_cfg ? cfg_word : (hit_stat ? stat_word : 32'h0000_0000);
      end
      if (psel_in && penable_in && pready_q && pwrite_in && hit_cfg) begin
         cfg_d.test_mode = pwdata_in[`DFGC_BIT_TEST];
         cfg_d.repeat_en = pwdata_in[`DFGC_BIT_REPEAT];
         cfg_d.all_dirty = pwdata_in[`DFGC_BIT_ALLDIRTY];
         cfg_d.insert = pwdata_in[`DFGC_BIT_INSERT];
         cfg_d.stop_lvl = pwdata_in[`DFGC_STOP_HI:`DFGC_STOP_LO];
         cfg_d.begin_lvl = pwdata_in[`DFGC_BEGIN_HI:`DFGC_BEGIN_LO];
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_q <= dfgc_pkg::dfgc_cfg_s'(12'h000);
         prdata_q <= `DFGC_CFG_RESET;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;

   a_apb_one_wait: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      psel_in && !penable_in |=> pready_out)
      else $error("pready missing in access cycle");

   ////////////////////////////////////////////////////////////////////
   // Test mode and pointer reset
   logic test_q, test_d;
   logic ptr_rst_q, ptr_rst_d;

   always_comb begin
      test_d = cfg_q.test_mode; // R1
      ptr_rst_d = cfg_q.test_mode && !test_q; // R2
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         test_q <= 1'b0;
         ptr_rst_q <= 1'b0;
      end else begin
         test_q <= test_d;
         ptr_rst_q <= ptr_rst_d;
      end
   end

   assign fifo_test_mode_out = test_q;
   assign fifo_ptr_reset_out = ptr_rst_q;

   sequence s_test_rise;
      $rose(cfg_q.test_mode);
   endsequence

   a_ptr_reset_rise: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R2
      s_test_rise |=> fifo_ptr_reset_out ##1 !fifo_ptr_reset_out)
      else $error("pointer reset not a single pulse on rise");
   a_ptr_reset_cause: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R2
      fifo_ptr_reset_out |-> $past(cfg_q.test_mode) && !$past(test_q))
      else $error("pointer reset without rising test bit");
   a_test_follows: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R1
      fifo_test_mode_out == $past(cfg_q.test_mode))
      else $error("test mode output lags wrongly");

   ////////////////////////////////////////////////////////////////////
   // Line repeat
   logic repeat_q, repeat_d;

   always_comb begin
      line_odd_d = line_odd_q;
      if (frame_start_in) begin
         line_odd_d = 1'b0;
      end else if (line_start_in) begin
         line_odd_d = !line_odd_q;
      end
      repeat_d = cfg_q.repeat_en && line_odd_d; // R3
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         line_odd_q <= 1'b0;
         repeat_q <= 1'b0;
      end else begin
         line_odd_q <= line_odd_d;
         repeat_q <= repeat_d;
      end
   end

   assign line_repeat_out = repeat_q;

   a_repeat_odd: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R3
      line_repeat_out |-> line_odd_q && $past(cfg_q.repeat_en))
      else $error("repeat on even line or while disabled");
   a_repeat_frame: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R3
      frame_start_in |=> !line_repeat_out)
      else $error("first line of frame repeated");

   ////////////////////////////////////////////////////////////////////
   // Dirty marking
   logic dset_q, dset_d;
   logic dall_q, dall_d;
   logic [LINE_W-1:0] dline_q, dline_d;

   always_comb begin
      dset_d = pixel_write_in;
      dall_d = 1'b0;
      dline_d = dline_q;
      if (pixel_write_in) begin
         dall_d = cfg_q.all_dirty; // R5
         dline_d = pixel_line_in; // R6
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dset_q <= 1'b0;
         dall_q <= 1'b0;
         dline_q <= '0;
      end else begin
         dset_q <= dset_d;
         dall_q <= dall_d;
         dline_q <= dline_d;
      end
   end

   assign dirty_set_out = dset_q;
   assign dirty_all_out = dall_q;
   assign dirty_line_out = dline_q;

   a_dirty_all: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R5
      pixel_write_in && cfg_q.all_dirty |=> dirty_set_out && dirty_all_out)
      else $error("whole frame not marked dirty");
   a_dirty_line: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R6
      pixel_write_in && !cfg_q.all_dirty |=> dirty_set_out && !dirty_all_out
         && dirty_line_out == $past(pixel_line_in))
      else $error("line dirty mark wrong");

   ////////////////////////////////////////////////////////////////////
   // Update and static frames
   logic upd_q, upd_d;

   always_comb begin
      frame_d = frame_q;
      if (frame_start_in) begin
         case (frame_q)
            dfgc_pkg::DFGC_UPDATE: begin
               frame_d = cfg_q.insert ? dfgc_pkg::DFGC_STATIC : dfgc_pkg::DFGC_UPDATE; // R7
            end
            dfgc_pkg::DFGC_STATIC: begin
               frame_d = dfgc_pkg::DFGC_UPDATE; // R7
            end
            default: begin
               frame_d = dfgc_pkg::DFGC_UPDATE;
            end
         endcase
      end
      upd_d = (frame_d == dfgc_pkg::DFGC_UPDATE); // R8
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         frame_q <= dfgc_pkg::DFGC_UPDATE;
         upd_q <= 1'b1;
      end else begin
         frame_q <= frame_d;
         upd_q <= upd_d;
      end
   end

   assign update_frame_out = upd_q; // R8

   sequence s_update_start;
      frame_start_in && update_frame_out;
   endsequence

   a_insert_static: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R7
      s_update_start and cfg_q.insert |=> !update_frame_out)
      else $error("static frame not inserted");
   a_no_double_static: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R7
      frame_start_in && !update_frame_out |=> update_frame_out)
      else $error("two static frames in a row");
   a_no_insert_off: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R7
      s_update_start and !cfg_q.insert |=> update_frame_out)
      else $error("static frame inserted while disabled");

   ////////////////////////////////////////////////////////////////////
   // Urgent fill request
   logic [DEPTH_W-1:0] begin_ent;
   logic [DEPTH_W-1:0] stop_ent;

   always_comb begin
      begin_ent = lvl_entries(cfg_q.begin_lvl);
      stop_ent = lvl_entries(cfg_q.stop_lvl);
      urgent_d = urgent_q;
      if (!urgent_q && fifo_depth_in <= begin_ent) begin
         urgent_d = 1'b1; // R9
      end else if (urgent_q && fifo_depth_in >= stop_ent) begin
         urgent_d = 1'b0; // R10
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         urgent_q <= 1'b0;
      end else begin
         urgent_q <= urgent_d;
      end
   end

   assign urgent_fill_req_out = urgent_q;

   a_urgent_begin: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R9
      !urgent_fill_req_out && fifo_depth_in <= lvl_entries(cfg_q.begin_lvl) |=> urgent_fill_req_out)
      else $error("urgent request not raised at begin level");
   a_urgent_stop: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R10
      urgent_fill_req_out && fifo_depth_in >= lvl_entries(cfg_q.stop_lvl) |=> !urgent_fill_req_out)
      else $error("urgent request not ended at stop level");
   a_urgent_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R10
      $fell(urgent_fill_req_out) |-> $past(fifo_depth_in) >= $past(stop_ent))
      else $error("urgent request dropped early");

endmodule // dfgc_top

// ==== dfgc_mem_model.sv ====
// Memory controller model that fills the display FIFO on urgent requests
module dfgc_mem_model (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic fill_req_in,
   input wire logic slow_in,
   input wire logic drain_in,
   output logic [7:0] depth_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] depth_q;
   logic [7:0] depth_d;
   always_comb begin
      depth_d = depth_q;
      if (fill_req_in && depth_q < 8'hF0) begin
         depth_d = depth_d + (slow_in ? 8'h02 : 8'h03);
      end
      if (drain_in && depth_d != 8'h00) begin
         depth_d = depth_d - 8'h01;
      end
   end
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         depth_q <= 8'h40;
      end else begin
         depth_q <= depth_d;
      end
   end
   assign depth_out = depth_q;
endmodule // dfgc_mem_model

// ==== display_fifo_general_config_tb.sv ====
// Register and control tests of the display FIFO configuration block
`include "dfgc_defs.svh"
module display_fifo_general_config_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, err;
   logic fs = 1'b0, ls = 1'b0, pw = 1'b0, drain = 1'b0, slow = 1'b0;
   logic [10:0] pline = 11'h000;
   logic [7:0] depth;
   logic test_mode, ptr_rst, rep, dset, dall, upd, req;
   logic [10:0] dline;
   int miscompares = 0, checked = 0, rises;
   always #20 clk = ~clk;
   dfgc_top dut (.clk_sys_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .fifo_depth_in(depth), .frame_start_in(fs),
      .line_start_in(ls), .pixel_write_in(pw), .pixel_line_in(pline), .fifo_test_mode_out(test_mode),
      .fifo_ptr_reset_out(ptr_rst), .line_repeat_out(rep), .dirty_set_out(dset), .dirty_all_out(dall),
      .dirty_line_out(dline), .update_frame_out(upd), .urgent_fill_req_out(req));
   dfgc_mem_model mem (.clk_sys_in(clk), .rst_n_in(rst_n), .fill_req_in(req), .slow_in(slow),
      .drain_in(drain), .depth_out(depth));
   ////////////////////////////////////////////////////////////////////////////////
   task give_verdict();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task pulse(input logic f, input logic l, input logic p);
      @(posedge clk);
      fs <= f;
      ls <= l;
      pw <= p;
      @(posedge clk);
      fs <= 1'b0;
      ls <= 1'b0;
      pw <= 1'b0;
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, `DFGC_CFG_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 16'h8308, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, `DFGC_STAT_OFS, 32'hF);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, `DFGC_CFG_OFS, 32'hFFFF_FFFF);
      apb(1'b0, `DFGC_CFG_OFS, 32'h0);
      chk(rd, 32'h0305_FF00);
      apb(1'b1, `DFGC_CFG_OFS, 32'h0);
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, `DFGC_CFG_OFS, 32'h0200_0000);
         @(posedge clk);
         #1;
         chk({30'h0, test_mode, ptr_rst}, 32'h3);
         @(posedge clk);
         #1;
         chk({30'h0, test_mode, ptr_rst}, 32'h2);
         apb(1'b0, `DFGC_STAT_OFS, 32'h0);
         chk(rd & 32'h4, 32'h4);
         apb(1'b1, `DFGC_CFG_OFS, 32'h0200_0000);
         repeat (2) @(posedge clk);
         #1;
         chk({30'h0, test_mode, ptr_rst}, 32'h2);
         apb(1'b1, `DFGC_CFG_OFS, 32'h0);
      end
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, `DFGC_CFG_OFS, k ? 32'h0004_0000 : 32'h0);
         pline <= 11'h155 + k[10:0];
         pulse(1'b0, 1'b0, 1'b1);
         chk({30'h0, dset, dall}, {30'h0, 1'b1, k[0]});
         chk({21'h0, dline}, {21'h0, 11'h155 + k[10:0]});
         @(posedge clk);
         #1;
         chk({31'h0, dset}, 32'h0);
      end
      apb(1'b1, `DFGC_CFG_OFS, 32'h0101_0000);
      pulse(1'b1, 1'b0, 1'b0);
      chk({30'h0, upd, rep}, 32'h0);
      pulse(1'b0, 1'b1, 1'b0);
      chk({30'h0, upd, rep}, 32'h1);
      pulse(1'b0, 1'b1, 1'b0);
      chk({30'h0, upd, rep}, 32'h0);
      pulse(1'b1, 1'b1, 1'b0);
      chk({30'h0, upd, rep}, 32'h2);
      apb(1'b1, `DFGC_CFG_OFS, 32'h0);
      pulse(1'b1, 1'b0, 1'b0);
      pulse(1'b0, 1'b1, 1'b0);
      chk({30'h0, upd, rep}, 32'h2);
      apb(1'b0, `DFGC_STAT_OFS, 32'h0);
      chk(rd, 32'hA);
      for (int k = 0; k < 2; k++) begin
         logic rq_p;
         logic [7:0] dp_p;
         apb(1'b1, `DFGC_CFG_OFS, 32'h0000_5200);
         slow <= k[0];
         drain <= 1'b1;
         rises = 0;
         rq_p = req;
         dp_p = depth;
         repeat (300) begin
            @(posedge clk);
            if (req === 1'b1 && rq_p === 1'b0) begin
               rises++;
               chk({31'h0, dp_p <= 8'd8}, 32'h1);
            end
            if (req === 1'b0 && rq_p === 1'b1) begin
               chk({31'h0, dp_p >= 8'd20}, 32'h1);
            end
            rq_p = req;
            dp_p = depth;
         end
         chk({31'h0, rises > 1}, 32'h1);
         drain <= 1'b0;
      end
      give_verdict();
   end
   initial begin
      repeat (4000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
endmodule // display_fifo_general_config_tb
